// file: logic/sar_bus_if.sv
`timescale 1ns/100ps
interface sar_bus_if;
	logic        cs_n;             // chip select
	logic        rd_n;             // read strobe
	logic        convert_start_n;  // convert start
	logic        mid_lane_select;  // mid byte select
	logic        low_bits_select;  // low two bits select
	logic        busy;             // conversion running
	logic [17:0] result_pins_o;    // device drive value
	logic [17:0] result_pins_oe;   // device output enable per pin
	logic [17:0] result_pins;      // resolved bus (ones when floating, pull-up)
	assign result_pins = result_pins_o | ~result_pins_oe;
	modport device (
		input  cs_n, rd_n, convert_start_n, mid_lane_select, low_bits_select,
		output busy, result_pins_o, result_pins_oe
	);
	modport host (
		output cs_n, rd_n, convert_start_n, mid_lane_select, low_bits_select,
		input  busy, result_pins
	);
endinterface : sar_bus_if

// file: logic/sar_readout_device.sv
// How it works
// - result is 18-bit straight binary code
// - drive pins only with select and read low
// - host avoids reads around start falling edge
// - both selects low: full word on pins
// - low-bits select: bits 1:0 on pins 3:2
// - mid-lane select: bits 9:2 on 17:10
// - both selects: bits 1:0 on 11:10
// - 16-bit host uses two reads
// - 8-bit host uses three reads
// - 8-bit host may skip third read
// - output follows selects, strobe held or toggled
// - first three power-up results are invalid
// - start during conversion causes internal reset
// - select falling during conversion causes reset
// - internal reset clears latches, busy low
// - sampling restarts after busy falls
// - busy high from start until done
// - conversion lasts 710 ns; CONV_CYCLES rounds down to 88 mclk cycles, 704 ns
`timescale 1ns/100ps
module sar_readout_device
	import sar_readout_pkg::*;
#(
	parameter int CONV_CNT = CONV_CYCLES   // conversion length in mclk cycles
) (
	// clock, reset, enable
	input  wire logic                mclk,
	input  wire logic                srst,
	input  wire logic                clk_en,
	// host side pins
	sar_bus_if.device                bus,
	// converter core side
	input  wire logic [RESULT_W-1:0] sample_code,   // code produced by the core
	output logic                     sampling,      // acquisition phase active
	output logic                     result_valid   // trim conversions done
);
	// ------------------------------------------------------------
	// timing summary
	// ------------------------------------------------------------
	// every pin is seen two cycles after it moves and its edges in the same
	// cycle; the data pins follow strobe and selects three
	// cycles late, so a host must wait that long, plus its own input
	// stages, before it samples a lane
	// busy is combinational from the sequencer, so it drops in the
	// very cycle an abort is taken
	// clock enable low freezes every register, the sync chains too,
	// so a frozen part misses pin edges instead of queueing them
	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [1:0] cs_sync_reg;        // chip select sync chain
	logic [1:0] rd_sync_reg;        // read strobe sync chain
	logic [1:0] cv_sync_reg;        // convert start sync chain
	logic [1:0] mid_sync_reg;       // mid select sync chain
	logic [1:0] low_sync_reg;       // low select sync chain
	logic       cs_prev_reg;        // last synced select
	logic       cv_prev_reg;        // last synced start
	// two stages on every pin; only stage 1 feeds logic
	// the edge registers read stage 1 as well, so a pin that goes
	// metastable in stage 0 never reaches the sequencer directly
	always_ff @(posedge mclk) begin
		if (srst) begin
			cs_sync_reg  <= 2'h3;
			rd_sync_reg  <= 2'h3;
			cv_sync_reg  <= 2'h3;
			mid_sync_reg <= 2'h0;
			low_sync_reg <= 2'h0;
			cs_prev_reg  <= 1'b1;
			cv_prev_reg  <= 1'b1;
		end else if (clk_en) begin
			cs_sync_reg  <= {cs_sync_reg[0], bus.cs_n};
			rd_sync_reg  <= {rd_sync_reg[0], bus.rd_n};
			cv_sync_reg  <= {cv_sync_reg[0], bus.convert_start_n};
			mid_sync_reg <= {mid_sync_reg[0], bus.mid_lane_select};
			low_sync_reg <= {low_sync_reg[0], bus.low_bits_select};
			cs_prev_reg  <= cs_sync_reg[1];
			cv_prev_reg  <= cv_sync_reg[1];
		end
	end
	wire cs_low  = ~cs_sync_reg[1];
	wire cs_fall = cs_prev_reg & ~cs_sync_reg[1];
	wire cv_fall = cv_prev_reg & ~cv_sync_reg[1];
	// ------------------------------------------------------------
	// conversion sequencer
	// ------------------------------------------------------------
	conv_state_t      state_reg;           // sequencer state
	logic [9:0]       conv_cnt_reg;        // cycles left in conversion
	logic [1:0]       trim_cnt_reg;        // trim conversions finished
	logic [RESULT_W-1:0] latch_reg;        // output result latch
	logic [RESULT_W-1:0] held_code_reg;    // code captured at hold edge
	wire  conv_done = (state_reg == ST_CONV) && (conv_cnt_reg == 10'h001);
	// abort: a start edge while selected, or a fresh select edge,
	// arriving while a conversion is still running
	wire  reset_hit = (state_reg == ST_CONV) && ((cv_fall && cs_low) || cs_fall);
	// state walk: idle, convert, one-cycle self reset
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= ST_IDLE;
		end else if (clk_en) begin
			case (state_reg)
				// waiting for a start edge while selected
				ST_IDLE: begin
					if (cv_fall && cs_low)
						state_reg <= ST_CONV;
				end
				// converting; a second start or a select edge aborts
				ST_CONV: begin
					if (reset_hit)
						state_reg <= ST_RST;
					else if (conv_done)
						state_reg <= ST_IDLE;
				end
				// one cycle of self reset, then sampling again
				ST_RST: begin
					state_reg <= ST_IDLE;       // self-clearing
				end
				// illegal code: recover to idle
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end
	// conversion timer, loaded at the hold edge
	// the code is captured at the start edge, so a core value that
	// moves during the conversion cannot disturb the word
	always_ff @(posedge mclk) begin
		if (srst) begin
			conv_cnt_reg  <= 10'h000;
			held_code_reg <= CODE_ZERO;
		end else if (clk_en) begin
			if (state_reg == ST_IDLE && cv_fall && cs_low) begin
				conv_cnt_reg  <= 10'(CONV_CNT);
				held_code_reg <= sample_code;    // sample to hold at start edge
			end else if (state_reg == ST_CONV && conv_cnt_reg != 10'h000) begin
				conv_cnt_reg <= conv_cnt_reg - 10'h001;
			end
		end
	end
	// result latch: updated at conversion end, cleared by internal reset
	// an abort wins over a finish in the same cycle, so a cut
	// conversion never lands in the latch
	always_ff @(posedge mclk) begin
		if (srst) begin
			latch_reg <= CODE_ZERO;
		end else if (clk_en) begin
			if (reset_hit)
				latch_reg <= CODE_ZERO;
			else if (conv_done)
				latch_reg <= held_code_reg;
		end
	end
	// trim counter; power-up results flagged invalid until three complete
	// conversions aborted before their last cycle never reach conv_done; an abort in the last cycle still counts
	always_ff @(posedge mclk) begin
		if (srst) begin
			trim_cnt_reg <= 2'h0;
		end else if (clk_en) begin
			if (conv_done && trim_cnt_reg != 2'(TRIM_CONVS))
				trim_cnt_reg <= trim_cnt_reg + 2'h1;
		end
	end
	// status outputs; busy drops in the very cycle an abort is taken,
	// and sampling resumes two cycles later when the self reset ends
	assign result_valid = (trim_cnt_reg == 2'(TRIM_CONVS)) && (state_reg == ST_IDLE);
	assign bus.busy     = (state_reg == ST_CONV) && !reset_hit;
	assign sampling     = (state_reg == ST_IDLE);
	// ------------------------------------------------------------
	// output lane mux
	// ------------------------------------------------------------
	// lane map by {mid, low}: 00 full word, 01 bits 1:0 on pins 3:2,
	// 10 bits 9:2 on pins 17:10, 11 bits 1:0 on pins 11:10
	logic [17:0] lane_next;   // pin pattern for current selects
	// ones fill every unused pin so narrow hosts see a fixed value
	always_comb begin
		lane_next = 18'h3ffff;
		case ({mid_sync_reg[1], low_sync_reg[1]})
			// full word, msb on the top pin
			2'b00: lane_next = latch_reg;
			// 16-bit host, second read
			2'b01: lane_next[LOW_FILL_LSB +: 2] = latch_reg[1:0];
			// byte host, middle byte on the top byte lane
			2'b10: lane_next[LOW_BYTE_LSB +: 8] = latch_reg[MID_LSB +: 8];
			// byte host, last two bits
			2'b11: lane_next[LOW_BYTE_LSB +: 2] = latch_reg[1:0];
			// unreachable; keep the idle pattern
			default: lane_next = 18'h3ffff;
		endcase
	end
	logic [17:0] pins_reg;   // registered pin data
	logic        oe_reg;     // registered drive enable
	// selects are tracked every cycle so held-low strobe reads follow them
	// the pins never float in this model: the enable says when they are
	// driven and the interface pulls released pins up to ones
	always_ff @(posedge mclk) begin
		if (srst) begin
			pins_reg <= 18'h3ffff;
			oe_reg   <= 1'b0;
		end else if (clk_en) begin
			pins_reg <= lane_next;
			oe_reg   <= ~cs_sync_reg[1] & ~rd_sync_reg[1];
		end
	end
	assign bus.result_pins_o  = pins_reg;
	// one enable for all eighteen pins; lanes never float separately
	assign bus.result_pins_oe = {18{oe_reg}};
endmodule : sar_readout_device

// file: logic/sar_readout_host.sv
`timescale 1ns/100ps
module sar_readout_host
	import sar_readout_pkg::*;
#(
	parameter int HOLD_CYC = 5   // cycles waited in each read phase before sampling: device lag 3 plus our 2 stages
) (
	// clock, reset, enable
	input  wire logic                mclk,
	input  wire logic                srst,
	input  wire logic                clk_en,
	// device side pins
	sar_bus_if.host                  bus,
	// user side
	input  wire logic                start_req,    // pulse: start a conversion
	input  wire logic [1:0]          bus_mode,     // 0:18-bit 1:16-bit 2:8-bit 3:8-bit short
	output logic [RESULT_W-1:0]      out_data,     // assembled result
	output logic                     out_valid,    // buffer head valid
	input  wire logic                out_ready,    // consumer ready
	output logic                     start_ready   // ready for start_req
);
	// ------------------------------------------------------------
	// pin sync and sequencer
	// ------------------------------------------------------------
	logic [1:0] busy_sync_reg;    // busy sync chain
	logic [17:0] pin_sync0_reg;   // data stage 0
	logic [17:0] pin_sync1_reg;   // data stage 1
	always_ff @(posedge mclk) begin
		if (srst) begin
			busy_sync_reg <= 2'h0;
			pin_sync0_reg <= 18'h3ffff;
			pin_sync1_reg <= 18'h3ffff;
		end else if (clk_en) begin
			busy_sync_reg <= {busy_sync_reg[0], bus.busy};
			pin_sync0_reg <= bus.result_pins;
			pin_sync1_reg <= pin_sync0_reg;
		end
	end
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_CONV = 5'b00010,
		H_WAIT = 5'b00100,
		H_READ = 5'b01000,
		H_PUSH = 5'b10000
	} host_state_t;
	host_state_t   hst_reg;       // host state
	logic [7:0]    tmr_reg;       // phase timer
	logic [1:0]    phase_reg;     // read phase index
	logic [1:0]    trim_reg;      // power-up results still to drop
	logic [17:0]   acc_reg;       // assembled word
	logic          buf_ready;     // buffer can accept
	wire [1:0] last_phase = (bus_mode == 2'd0) ? 2'd0 :
	                        (bus_mode == 2'd1 || bus_mode == 2'd3) ? 2'd1 : 2'd2;
	assign start_ready = (hst_reg == H_IDLE);
	// convert start pulse is wide enough for the device sync; reads only
	// happen once busy has fallen, and the start edge waits out the quiet
	// time after the last read, so no read sits close to the edge
	always_ff @(posedge mclk) begin
		if (srst) begin
			hst_reg   <= H_IDLE;
			tmr_reg   <= 8'h00;
			phase_reg <= 2'h0;
			trim_reg  <= 2'(TRIM_CONVS);
			acc_reg   <= CODE_ZERO;
		end else if (clk_en) begin
			case (hst_reg)
				H_IDLE: begin
					tmr_reg <= 8'h00;
					if (start_req)
						hst_reg <= H_CONV;
				end
				H_CONV: begin
					tmr_reg <= tmr_reg + 8'h01;
					if (busy_sync_reg[1])
						hst_reg <= H_WAIT;
					else if (tmr_reg == 8'hff)
						hst_reg <= H_IDLE;     // device never answered
				end
				H_WAIT: begin
					tmr_reg <= 8'h00;
					phase_reg <= 2'h0;
					if (!busy_sync_reg[1])
						hst_reg <= H_READ;
				end
				H_READ: begin
					tmr_reg <= tmr_reg + 8'h01;
					if (tmr_reg == 8'(HOLD_CYC)) begin
						tmr_reg <= 8'h00;
						case (bus_mode)
							2'd0: acc_reg <= pin_sync1_reg;
							2'd1: begin
								if (phase_reg == 2'd0)
									acc_reg[17:2] <= pin_sync1_reg[17:2];
								else
									acc_reg[1:0] <= pin_sync1_reg[LOW_FILL_LSB +: 2];
							end
							default: begin
								if (phase_reg == 2'd0)
									acc_reg[17:10] <= pin_sync1_reg[17:10];
								else if (phase_reg == 2'd1)
									acc_reg[9:2] <= pin_sync1_reg[17:10];
								else
									acc_reg[1:0] <= pin_sync1_reg[LOW_BYTE_LSB +: 2];
							end
						endcase
						if (phase_reg == 2'd0 && bus_mode == 2'd3)
							acc_reg[1:0] <= 2'h0;
						if (phase_reg == last_phase)
							hst_reg <= H_PUSH;
						else
							phase_reg <= phase_reg + 2'h1;
					end
				end
				H_PUSH: begin
					if (trim_reg != 2'h0) begin
						trim_reg <= trim_reg - 2'h1;
						hst_reg  <= H_IDLE;
					end else if (buf_ready) begin
						hst_reg <= H_IDLE;
					end
				end
				default: hst_reg <= H_IDLE;
			endcase
		end
	end
	// strobe held low across phases; selects step per phase
	assign bus.cs_n            = 1'b0;
	assign bus.convert_start_n = (hst_reg != H_CONV) || busy_sync_reg[1] ||
		(tmr_reg < 8'(QUIET_PRE_CYC));
	assign bus.rd_n            = (hst_reg != H_READ);
	assign bus.low_bits_select = (hst_reg == H_READ) &&
		((bus_mode == 2'd1 && phase_reg == 2'd1) || phase_reg == 2'd2);
	assign bus.mid_lane_select = (hst_reg == H_READ) && bus_mode[1] && phase_reg != 2'd0;
	// ------------------------------------------------------------
	// two-entry output buffer
	// ------------------------------------------------------------
	logic [17:0] buf_mem_reg [2];   // entries
	logic        wr_ptr_reg;
	logic        rd_ptr_reg;
	logic [1:0]  cnt_reg;
	wire push = clk_en && hst_reg == H_PUSH && trim_reg == 2'h0 && buf_ready;
	wire pop  = clk_en && out_valid && out_ready;
	assign buf_ready = (cnt_reg != 2'd2);
	assign out_valid = (cnt_reg != 2'd0);
	assign out_data  = buf_mem_reg[rd_ptr_reg];
	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_ptr_reg     <= 1'b0;
			rd_ptr_reg     <= 1'b0;
			cnt_reg        <= 2'd0;
			buf_mem_reg[0] <= CODE_ZERO;
			buf_mem_reg[1] <= CODE_ZERO;
		end else begin
			if (push) begin
				buf_mem_reg[wr_ptr_reg] <= acc_reg;
				wr_ptr_reg <= ~wr_ptr_reg;
			end
			if (pop)
				rd_ptr_reg <= ~rd_ptr_reg;
			cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end
endmodule : sar_readout_host

// file: logic/sar_readout_pkg.sv
package sar_readout_pkg;
	// ------------------------------------------------------------
	// result format and timing
	// ------------------------------------------------------------
	localparam int            RESULT_W        = 18;          // result word width
	localparam int            CODE_SPAN       = 262144;      // codes per reference span
	localparam logic [17:0]   CODE_FULL       = 18'h3ffff;   // full scale minus one lsb
	localparam logic [17:0]   CODE_MID        = 18'h20000;   // half scale
	localparam logic [17:0]   CODE_ZERO       = 18'h00000;   // zero input / cleared latch
	localparam int            CLK_PERIOD_PS   = 8000;        // mclk period
	localparam int            CONV_TIME_NS    = 710;         // conversion time
	localparam int            CONV_CYCLES     = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int            QUIET_PRE_NS    = 50;          // quiet zone before start edge
	localparam int            QUIET_POST_NS   = 40;          // quiet zone after start edge
	localparam int            QUIET_PRE_CYC   = (QUIET_PRE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int            QUIET_POST_CYC  = (QUIET_POST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int            TRIM_CONVS      = 3;           // power-up conversions discarded
	localparam int            LOW_FILL_LSB    = 2;           // low-bit pair on 16-bit lane
	localparam int            LOW_BYTE_LSB    = 10;          // low-bit pair / byte lane base
	localparam int            MID_LSB         = 2;           // lowest result bit of mid byte
	// ------------------------------------------------------------
	// device conversion states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_CONV = 3'b010,
		ST_RST  = 3'b100
	} conv_state_t;
endpackage : sar_readout_pkg

// file: sim/sar_adc_parallel_readout_tb_top.sv
`timescale 1ns/100ps
module sar_adc_parallel_readout_tb_top;
	import sar_readout_pkg::*;
	localparam int CONV_N = 40;    // shortened, still long enough to abort mid-run
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        start_req = 1'b0;
	logic [1:0]  bus_mode = 2'h0;
	logic        out_ready = 1'b0;
	logic        stall = 1'b0;     // holds the consumer off to fill the buffer
	logic        clk_en_b = 1'b1;  // freezes the fault device
	logic [17:0] code_a = 18'h0;   // core code of the hosted device
	logic [17:0] code_b = 18'h0;   // core code of the fault device
	logic [17:0] out_data;
	logic        out_valid, start_ready, sampling_a, valid_a, sampling_b, valid_b;
	logic [17:0] exp_q[$];         // words the host should hand out, in order
	logic [17:0] corner [3] = '{CODE_FULL, CODE_MID, CODE_ZERO};
	int          mismatches = 0;
	int          total_checks = 0;
	int          trims = TRIM_CONVS;
	integer      seed = 32'hd7ae;
	sar_bus_if main_bus ();
	sar_bus_if fault_bus ();       // second device, driven off-rule by the bench
	// ------------------------------------------------------------
	// clock and instances
	// ------------------------------------------------------------
	always #4 mclk = ~mclk;
	sar_readout_device #(.CONV_CNT(CONV_N)) sar_readout_device_inst (.mclk(mclk), .srst(srst),
		.clk_en(1'b1), .bus(main_bus), .sample_code(code_a), .sampling(sampling_a),
		.result_valid(valid_a));
	sar_readout_device #(.CONV_CNT(CONV_N)) sar_readout_device_inst2 (.mclk(mclk), .srst(srst),
		.clk_en(clk_en_b), .bus(fault_bus), .sample_code(code_b), .sampling(sampling_b),
		.result_valid(valid_b));
	sar_readout_host sar_readout_host_inst (.mclk(mclk), .srst(srst), .clk_en(1'b1),
		.bus(main_bus), .start_req(start_req), .bus_mode(bus_mode), .out_data(out_data),
		.out_valid(out_valid), .out_ready(out_ready), .start_ready(start_ready));
	sar_readout_properties #(.CONV_CNT(CONV_N)) sar_readout_properties_inst (.mclk(mclk),
		.srst(srst), .cs_n(main_bus.cs_n), .rd_n(main_bus.rd_n),
		.convert_start_n(main_bus.convert_start_n), .mid_lane_select(main_bus.mid_lane_select),
		.low_bits_select(main_bus.low_bits_select), .busy(main_bus.busy),
		.result_pins_o(main_bus.result_pins_o), .result_pins_oe(main_bus.result_pins_oe));
	// ------------------------------------------------------------
	// shared tasks and expectations
	// ------------------------------------------------------------
	task automatic tick;
		@(posedge mclk);
		#1;
	endtask : tick
	task automatic check(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("ERROR %0t: %s", $time, msg);
		end
	endtask : check
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : final_report
	// expected pin image for one select setting
	function automatic logic [17:0] lane(input logic [17:0] c, input logic mid, input logic low);
		case ({mid, low})
			2'b00: lane = c;
			2'b01: lane = {14'h3fff, c[1:0], 2'h3};
			2'b10: lane = {c[9:2], 10'h3ff};
			default: lane = {6'h3f, c[1:0], 10'h3ff};
		endcase
	endfunction : lane
	// one hosted conversion; trim results are never queued
	task automatic host_conv(input logic [17:0] c, input logic [1:0] m);
		int n;
		n = 0;
		while (start_ready !== 1'b1 && n < 500) begin
			tick;
			n++;
		end
		check(start_ready === 1'b1, "host never ready");
		code_a = c;
		bus_mode = m;
		start_req = 1'b1;
		tick;
		start_req = 1'b0;
		if (trims > 0) begin
			trims--;
		end else begin
			exp_q.push_back(m == 2'h3 ? {c[17:2], 2'h0} : c);
		end
	endtask : host_conv
	// convert start on the fault device, held four cycles
	task automatic dev_start(input logic [17:0] c);
		code_b = c;
		fault_bus.convert_start_n = 1'b0;
		repeat (4) tick;
		fault_bus.convert_start_n = 1'b1;
		check(fault_bus.busy === 1'b1, "busy missing");
	endtask : dev_start
	task automatic dev_done;
		int n;
		n = 0;
		while (fault_bus.busy !== 1'b0 && n < 200) begin
			tick;
			n++;
		end
		check(n > CONV_N - 8 && n <= CONV_N, "conversion length off");
	endtask : dev_done
	// read one lane; hold keeps the strobe low into the next read
	task automatic dev_read(input logic mid, low, hold, input logic [17:0] e);
		fault_bus.mid_lane_select = mid;
		fault_bus.low_bits_select = low;
		fault_bus.rd_n = 1'b0;
		repeat (5) tick;
		check(fault_bus.result_pins === e, "lane data wrong");
		check(fault_bus.result_pins_oe === 18'h3ffff, "pins not driven");
		if (!hold) begin
			fault_bus.rd_n = 1'b1;
			repeat (5) tick;
			check(fault_bus.result_pins_oe === 18'h0, "pins not released");
		end
	endtask : dev_read
	// a read mid-run shows the old word, then a restart or select clears it
	task automatic dev_abort(input logic by_cs, input logic [17:0] prior);
		dev_start(CODE_MID);
		repeat (2) tick;                   // quiet time after the start edge
		dev_read(1'b0, 1'b0, 1'b0, prior);
		repeat (2) tick;                   // quiet time before the abort edge
		fault_bus.cs_n = by_cs;
		fault_bus.convert_start_n = by_cs;
		repeat (3) tick;
		fault_bus.cs_n = 1'b0;
		fault_bus.convert_start_n = 1'b1;
		repeat (6) tick;
		check(fault_bus.busy === 1'b0, "no internal reset");
		check(sampling_b === 1'b1, "no new sampling period");
		dev_read(1'b0, 1'b0, 1'b0, CODE_ZERO);
	endtask : dev_abort
	// ------------------------------------------------------------
	// consumer side of the host buffer, stalling at random
	// ------------------------------------------------------------
	always @(posedge mclk) begin
		if (!srst && out_valid === 1'b1 && out_ready === 1'b1) begin
			if (exp_q.size() == 0) begin
				check(1'b0, "unexpected word");
			end else begin
				check(out_data === exp_q.pop_front(), "word wrong");
			end
		end
	end
	always @(posedge mclk) begin
		#1;
		out_ready = !stall && ($random(seed) % 2 != 0);
	end
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		fault_bus.cs_n = 1'b0;
		fault_bus.rd_n = 1'b1;
		fault_bus.convert_start_n = 1'b1;
		fault_bus.mid_lane_select = 1'b0;
		fault_bus.low_bits_select = 1'b0;
		repeat (10) tick;
		srst = 1'b0;
		tick;
		// hosted pair: trim, then every bus mode with corner and random codes
		for (int i = 0; i < 3; i++) begin
			host_conv(18'($random(seed)), 2'h0);
		end
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 5; k++) begin
				host_conv(k < 3 ? corner[k] : 18'($random(seed)), 2'(m));
			end
		end
		// fill the two-entry buffer with the consumer stalled, then drain
		stall = 1'b1;
		host_conv(CODE_MID, 2'h1);
		host_conv(CODE_FULL, 2'h2);
		repeat (100) tick;
		check(out_valid === 1'b1, "buffer empty while stalled");
		stall = 1'b0;
		repeat (60) tick;
		check(exp_q.size() == 0, "words left undelivered");
		// fault device: trim flag and lane map, strobe toggled or held
		for (int i = 0; i < 6; i++) begin
			check(valid_b === (i >= 3), "trim flag wrong");
			dev_start(i < 3 ? 18'($random(seed)) : corner[i - 3]);
			dev_done;
			for (int m = 0; m < 4 && i >= 3; m++) begin
				dev_read(m[1], m[0], i[0], lane(code_b, m[1], m[0]));
			end
			fault_bus.rd_n = 1'b1;
			repeat (8) tick;
		end
		// a read while deselected must leave the pins floating
		fault_bus.cs_n = 1'b1;
		fault_bus.rd_n = 1'b0;
		repeat (5) tick;
		check(fault_bus.result_pins_oe === 18'h0, "pins driven while deselected");
		fault_bus.rd_n = 1'b1;
		fault_bus.cs_n = 1'b0;
		repeat (8) tick;
		// freeze mid-conversion: the count must resume, not run on
		dev_start(CODE_FULL);
		clk_en_b = 1'b0;
		repeat (20) tick;
		clk_en_b = 1'b1;
		dev_done;
		repeat (8) tick;
		dev_abort(1'b0, CODE_FULL);
		repeat (8) tick;
		dev_abort(1'b1, CODE_ZERO);
		final_report;
	end
	// watchdog, well beyond the expected run length
	initial begin
		#(20000 * 8);
		mismatches++;
		$display("ERROR %0t: watchdog expired", $time);
		final_report;
	end
endmodule : sar_adc_parallel_readout_tb_top

// file: sim/sar_readout_properties.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// bus properties between the host and device ends
// ------------------------------------------------------------
module sar_readout_properties
	import sar_readout_pkg::*;
#(
	parameter int CONV_CNT = CONV_CYCLES   // conversion length in mclk cycles
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        srst,
	// host driven pins
	input  wire logic        cs_n,
	input  wire logic        rd_n,
	input  wire logic        convert_start_n,
	input  wire logic        mid_lane_select,
	input  wire logic        low_bits_select,
	// device driven pins
	input  wire logic        busy,
	input  wire logic [17:0] result_pins_o,
	input  wire logic [17:0] result_pins_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	int busy_cnt_reg;   // length of the running busy stretch
	int rd_hi_reg;      // cycles the read strobe stayed high, saturates at 15
	// busy stretch counter, cleared whenever busy is low
	always_ff @(posedge mclk) begin
		if (srst || !busy) begin
			busy_cnt_reg <= 0;
		end else begin
			busy_cnt_reg <= busy_cnt_reg + 1;
		end
	end
	// reset holds the strobe high, so the quiet count starts full
	always_ff @(posedge mclk) begin
		if (srst) begin
			rd_hi_reg <= 15;
		end else if (!rd_n) begin
			rd_hi_reg <= 0;
		end else if (rd_hi_reg < 15) begin
			rd_hi_reg <= rd_hi_reg + 1;
		end
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	a_float_idle: assert property ((cs_n || rd_n) [*5] |-> result_pins_oe == 18'h0)
		else $error("data pins driven outside a read");
	a_drive_read: assert property ((!cs_n && !rd_n) [*5] |-> result_pins_oe == 18'h3ffff)
		else $error("data pins not driven during a read");
	a_low_pair_fill: assert property ((!rd_n && low_bits_select && !mid_lane_select) [*5]
		|-> result_pins_o[17:4] == 14'h3fff && result_pins_o[1:0] == 2'h3)
		else $error("low pair lane fill wrong");
	a_mid_byte_fill: assert property ((!rd_n && mid_lane_select && !low_bits_select) [*5]
		|-> result_pins_o[9:0] == 10'h3ff)
		else $error("mid byte lane fill wrong");
	a_byte_pair_fill: assert property ((!rd_n && mid_lane_select && low_bits_select) [*5]
		|-> result_pins_o[17:12] == 6'h3f && result_pins_o[9:0] == 10'h3ff)
		else $error("byte pair lane fill wrong");
	a_busy_rise: assert property ($fell(convert_start_n) && !cs_n && !busy |-> ##[1:5] busy)
		else $error("busy did not follow convert start");
	a_conv_length: assert property ($fell(busy) |-> busy_cnt_reg == CONV_CNT)
		else $error("conversion length wrong");
	a_busy_bounded: assert property (busy |-> busy_cnt_reg < CONV_CNT)
		else $error("busy held too long");
	a_quiet_before: assert property ($fell(convert_start_n) |-> rd_hi_reg >= QUIET_PRE_CYC)
		else $error("read too close before convert start");
	a_quiet_after: assert property ($fell(convert_start_n) |-> rd_n [*5])
		else $error("read too close after convert start");
	// main scenarios reached
	c_conv_done: cover property ($fell(busy));
	c_low_pair: cover property (!rd_n && low_bits_select && !mid_lane_select);
	c_byte_pair: cover property (!rd_n && low_bits_select && mid_lane_select);
endmodule : sar_readout_properties
